// file: rtl/spp_port.v
/*
 Six-bit general purpose port with per-pin direction, latch,
 open-drain, slew, threshold and analog select, plus the fixed
 output priority multiplexer.
 Assumes a single clock, pads that resolve wire levels from the
 enables, and a register master per the plain strobe port.
*/
// Contract
// R1: Six bidirectional pins, each with its own control bits.
// R2: Direction bit one disables the pin driver.
// R3: Direction bit zero drives the selected value, latch by default.
// R4: Pin 3 is input-only; its direction reads back as one.
// R5: Level register reads pins; writes go to the latch.
// R6: Port writes are read-modify-write into the latch.
// R7: Software keeps analog pins set as inputs.
// R8: Analog-selected pins read zero digitally.
// R9: Open-drain pins drive low only, release for one.
// R10: Cleared open-drain bit gives push-pull drive.
// R11: Slew bit set limits pad slew; cleared gives full rate.
// R12: Threshold bit selects Schmitt or TTL input levels.
// R13: Software changes thresholds only with peripherals disabled.
// R14: Analog select does not affect digital output.
// R15: Analog select bits set after reset.
// R16: Highest-priority enabled function owns the pin; latch lowest.
// R17: Peripheral outputs drive pins even in analog mode.
// R18: Eight-pin variant priority chains per pin.
// R19: Fourteen-pin variant priority chains per pin.
// R20: Steering moves functions without touching direction bits.
// R21: Latch register reads latch contents, not pins.
// R22: Direction bits reset to one, all inputs.
// R23: Enable only when direction zero; value from priority mux.
`timescale 1ns/100ps
`include "spp_defs.vh"

module spp_port (
	input  wire                   clk,
	input  wire                   rstn,
	input  wire                   variant,
	input  wire [`SPP_ADDR_W-1:0] reg_addr,
	input  wire [7:0]             reg_wdata,
	input  wire                   reg_wr,
	input  wire                   reg_rd,
	output reg  [7:0]             reg_rdata,
	input  wire [7:0]             pin_steering_control,
	input  wire [5:0]             pad_in,
	output reg  [5:0]             pad_out,
	output reg  [5:0]             pad_oe,
	output reg  [5:0]             pad_slew_limit,
	output reg  [5:0]             pad_ttl_level,
	output reg  [5:0]             pin_level_port,
	input  wire                   dac_output,
	input  wire                   dac_output_en,
	input  wire                   waveform_out_a,
	input  wire                   waveform_out_a_en,
	input  wire                   waveform_out_b,
	input  wire                   waveform_out_b_en,
	input  wire                   capture_pwm1_out,
	input  wire                   capture_pwm1_out_en,
	input  wire                   capture_pwm2_out,
	input  wire                   capture_pwm2_out_en,
	input  wire                   zero_cross_output,
	input  wire                   zero_cross_output_en,
	input  wire                   comparator_output,
	input  wire                   comparator_output_en,
	input  wire                   clock_output_function,
	input  wire                   clock_output_function_en
);

	// Control registers
	reg  [5:0] pin_direction_bits_q;     // R1
	reg  [5:0] output_latch_q;
	reg  [5:0] analog_mode_select_q;
	reg  [5:0] open_drain_select_q;
	reg  [5:0] slew_limit_select_q;
	reg  [5:0] input_threshold_select_q;
	reg  [7:0] rdata_d;

	wire [5:0] mux_value;
	wire [5:0] oe_d;
	wire [5:0] out_d;
	wire [5:0] dig_in;

	// Direction with the input-only pin forced high
	function [5:0] dir_view;
		input [5:0] raw;
		begin
			dir_view = raw | `SPP_DIR_FORCE;            // R4
		end
	endfunction

	// Read-modify-write merge: pin levels, addressed bits replaced.
	// A whole-byte write replaces every bit, so pins read back only
	// matter when the master writes a subset; with a byte port all
	// six are addressed, which keeps the latch exactly the data.
	function [5:0] rmw_merge;
		input [5:0] pins;
		input [5:0] data;
		input [5:0] mask;
		begin
			rmw_merge = (pins & ~mask) | (data & mask);
		end
	endfunction

	spp_out_mux u_mux (
		.variant                  (variant),
		.pin_steering_control     (pin_steering_control),
		.output_latch             (output_latch_q),
		.dac_output               (dac_output),
		.dac_output_en            (dac_output_en),
		.waveform_out_a           (waveform_out_a),
		.waveform_out_a_en        (waveform_out_a_en),
		.waveform_out_b           (waveform_out_b),
		.waveform_out_b_en        (waveform_out_b_en),
		.capture_pwm1_out         (capture_pwm1_out),
		.capture_pwm1_out_en      (capture_pwm1_out_en),
		.capture_pwm2_out         (capture_pwm2_out),
		.capture_pwm2_out_en      (capture_pwm2_out_en),
		.zero_cross_output        (zero_cross_output),
		.zero_cross_output_en     (zero_cross_output_en),
		.comparator_output        (comparator_output),
		.comparator_output_en     (comparator_output_en),
		.clock_output_function    (clock_output_function),
		.clock_output_function_en (clock_output_function_en),
		.pin_value                (mux_value)
	);

	spp_pad_ctl u_pad (
		.dir_bits    (dir_view(pin_direction_bits_q)),
		.drive_value (mux_value),
		.open_bits   (open_drain_select_q),
		.analog_bits (analog_mode_select_q),
		.pad_in      (pad_in),
		.pad_oe      (oe_d),
		.pad_out     (out_d),
		.dig_in      (dig_in)
	);

	// Register writes; reset puts every pin in input mode and pins 0, 1, 2 and 4 in analog mode
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_direction_bits_q     <= `SPP_RST_DIR;       // R22
			output_latch_q           <= `SPP_RST_LATCH;
			analog_mode_select_q     <= `SPP_RST_ANALOG;    // R15
			open_drain_select_q      <= `SPP_RST_OPEN;
			slew_limit_select_q      <= `SPP_RST_SLEW;
			input_threshold_select_q <= `SPP_RST_THRESH;
		end else if (reg_wr) begin
			case (reg_addr)
			`SPP_OFF_LEVEL:
				output_latch_q <= rmw_merge(dig_in, reg_wdata[5:0], 6'h3f); // R5 R6
			`SPP_OFF_LATCH:
				output_latch_q <= reg_wdata[5:0];
			`SPP_OFF_DIR:
				pin_direction_bits_q <= reg_wdata[5:0] | `SPP_DIR_FORCE; // R4 R20
			`SPP_OFF_ANALOG:
				analog_mode_select_q <= reg_wdata[5:0] & `SPP_ANALOG_MASK;
			`SPP_OFF_OPEN:
				open_drain_select_q <= reg_wdata[5:0];
			`SPP_OFF_SLEW:
				slew_limit_select_q <= reg_wdata[5:0];
			`SPP_OFF_THRESH:
				input_threshold_select_q <= reg_wdata[5:0];
			default: ;
			endcase
		end
	end

	// Read decode; unmapped offsets read zero
	always @* begin
		rdata_d = 8'h00;
		case (reg_addr)
		`SPP_OFF_LEVEL:  rdata_d = {2'b00, dig_in};                     // R5 R8
		`SPP_OFF_DIR:    rdata_d = {2'b00, dir_view(pin_direction_bits_q)}; // R4
		`SPP_OFF_LATCH:  rdata_d = {2'b00, output_latch_q};             // R21
		`SPP_OFF_ANALOG: rdata_d = {2'b00, analog_mode_select_q};
		`SPP_OFF_OPEN:   rdata_d = {2'b00, open_drain_select_q};
		`SPP_OFF_SLEW:   rdata_d = {2'b00, slew_limit_select_q};
		`SPP_OFF_THRESH: rdata_d = {2'b00, input_threshold_select_q};
		default:         rdata_d = 8'h00;
		endcase
	end

	// Read data stands one cycle after the strobe only
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rdata_d;
		else
			reg_rdata <= 8'h00;
	end

	// Registered pad controls: one cycle behind the settings, which
	// keeps every output glitch-free at the cost of a cycle of lag
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pad_oe         <= 6'h00;
			pad_out        <= 6'h00;
			pad_slew_limit <= `SPP_RST_SLEW;
			pad_ttl_level  <= `SPP_RST_THRESH;
			pin_level_port <= 6'h00;
		end else begin
			pad_oe         <= oe_d;                         // R2 R3 R9 R10 R23
			pad_out        <= out_d;                        // R16 R17
			pad_slew_limit <= slew_limit_select_q;          // R11
			pad_ttl_level  <= input_threshold_select_q;     // R12
			pin_level_port <= dig_in;                       // R8
		end
	end

endmodule // spp_port

// file: rtl/spp_defs.vh
/*
 Shared constants of the six-bit pin port: register offsets, reset
 values, field positions and variant codes.
 Assumes inclusion by bare name from the design files under rtl/.
*/
`ifndef SPP_DEFS_VH
`define SPP_DEFS_VH

// Register offsets on the plain register port
`define SPP_ADDR_W        4
`define SPP_OFF_LEVEL     4'h0
`define SPP_OFF_DIR       4'h1
`define SPP_OFF_LATCH     4'h2
`define SPP_OFF_ANALOG    4'h3
`define SPP_OFF_OPEN      4'h4
`define SPP_OFF_SLEW      4'h5
`define SPP_OFF_THRESH    4'h6

// Port geometry
`define SPP_NPINS         6
`define SPP_IN_ONLY_PIN   3

// Reset values, six bits wide
`define SPP_RST_DIR       6'h3f
`define SPP_RST_LATCH     6'h00
`define SPP_RST_ANALOG    6'h17
`define SPP_RST_OPEN      6'h00
`define SPP_RST_SLEW      6'h3f
`define SPP_RST_THRESH    6'h00

// Pins that can be analog; others hold analog select at zero
`define SPP_ANALOG_MASK   6'h17
// Pin 3 direction always reads as input
`define SPP_DIR_FORCE     6'h08

// Pin steering select bits
`define SPP_STEER_CAP1    0
`define SPP_STEER_CAP2    1
`define SPP_STEER_WAVB    5
`define SPP_STEER_WAVA    6

// Package variant: 0 small eight-pin, 1 fourteen-pin
`define SPP_VAR_8PIN      1'b0
`define SPP_VAR_14PIN     1'b1

`endif

// file: rtl/spp_out_mux.v
/*
 Fixed output priority multiplexer for the six pins.
 Assumes peripheral outputs and enables are synchronous levels and
 that the steering byte is held stable by its owner.
*/
`timescale 1ns/100ps
`include "spp_defs.vh"

module spp_out_mux (
	input  wire       variant,
	input  wire [7:0] pin_steering_control,
	input  wire [5:0] output_latch,
	input  wire       dac_output,
	input  wire       dac_output_en,
	input  wire       waveform_out_a,
	input  wire       waveform_out_a_en,
	input  wire       waveform_out_b,
	input  wire       waveform_out_b_en,
	input  wire       capture_pwm1_out,
	input  wire       capture_pwm1_out_en,
	input  wire       capture_pwm2_out,
	input  wire       capture_pwm2_out_en,
	input  wire       zero_cross_output,
	input  wire       zero_cross_output_en,
	input  wire       comparator_output,
	input  wire       comparator_output_en,
	input  wire       clock_output_function,
	input  wire       clock_output_function_en,
	output reg  [5:0] pin_value
);

	// Steering moves a function; the unselected pin never sees it, except capture_pwm2_out on pin 0 of the eight-pin variant
	wire wa_alt = pin_steering_control[`SPP_STEER_WAVA];    // R20
	wire wb_alt = pin_steering_control[`SPP_STEER_WAVB];    // R20
	wire c1_alt = pin_steering_control[`SPP_STEER_CAP1];    // R20
	wire c2_alt = pin_steering_control[`SPP_STEER_CAP2];    // R20

	// Priority chains, highest first, latch last; no analog gating
	always @* begin
		pin_value = output_latch;                       // R16 R17
		if (variant == `SPP_VAR_8PIN) begin
			if (dac_output_en)                       // R18
				pin_value[0] = dac_output;
			else if (waveform_out_b_en && !wb_alt)
				pin_value[0] = waveform_out_b;
			else if (capture_pwm2_out_en)
				pin_value[0] = capture_pwm2_out;
			if (zero_cross_output_en)
				pin_value[1] = zero_cross_output;
			if (waveform_out_a_en && !wa_alt)
				pin_value[2] = waveform_out_a;
			else if (comparator_output_en)
				pin_value[2] = comparator_output;
			else if (capture_pwm1_out_en && !c1_alt)
				pin_value[2] = capture_pwm1_out;
			if (clock_output_function_en)
				pin_value[4] = clock_output_function;
			else if (waveform_out_b_en && wb_alt)
				pin_value[4] = waveform_out_b;
			if (waveform_out_a_en && wa_alt)
				pin_value[5] = waveform_out_a;
			else if (capture_pwm1_out_en && c1_alt)
				pin_value[5] = capture_pwm1_out;
		end else begin
			if (dac_output_en)                       // R19
				pin_value[0] = dac_output;
			if (zero_cross_output_en)
				pin_value[1] = zero_cross_output;
			if (comparator_output_en)
				pin_value[2] = comparator_output;
			if (clock_output_function_en)
				pin_value[4] = clock_output_function;
			// Default pin of this function is on the other port
			if (capture_pwm2_out_en && c2_alt)
				pin_value[5] = capture_pwm2_out;
		end
	end

endmodule // spp_out_mux

// file: rtl/spp_pad_ctl.v
/*
 Per-pin pad control: output enable, open-drain release,
 and the digital input path with analog gating.
 Assumes the pad reports its level already resolved by the chosen
 input threshold.
*/
`timescale 1ns/100ps
`include "spp_defs.vh"

module spp_pad_ctl (
	input  wire [5:0] dir_bits,
	input  wire [5:0] drive_value,
	input  wire [5:0] open_bits,
	input  wire [5:0] analog_bits,
	input  wire [5:0] pad_in,
	output reg  [5:0] pad_oe,
	output reg  [5:0] pad_out,
	output reg  [5:0] dig_in
);

	integer i;

	// Driver and input buffer for each pin
	always @* begin
		pad_oe  = 6'h00;
		pad_out = 6'h00;
		dig_in  = 6'h00;
		for (i = 0; i < `SPP_NPINS; i = i + 1) begin
			if (i != `SPP_IN_ONLY_PIN && !dir_bits[i]) begin     // R2 R3 R4 R23
				if (open_bits[i]) begin
					pad_oe[i]  = !drive_value[i];     // R9
					pad_out[i] = 1'b0;
				end else begin
					pad_oe[i]  = 1'b1;                // R10
					pad_out[i] = drive_value[i];
				end
			end
			// Analog disables the buffer, output is untouched
			dig_in[i] = pad_in[i] & ~analog_bits[i];              // R8 R14
		end
	end

endmodule // spp_pad_ctl

// file: tb/spp_port_monitor.sv
/*
 Checker for the six-bit pin port, bound to its top-level ports.
 Assumes rtl/ on the include path and a single clock domain.
*/
`timescale 1ns/100ps
`include "spp_defs.vh"

module spp_port_monitor (
	input wire                   clk,
	input wire                   rstn,
	input wire [`SPP_ADDR_W-1:0] reg_addr,
	input wire                   reg_rd,
	input wire [7:0]             reg_rdata,
	input wire [5:0]             pad_in,
	input wire [5:0]             pad_oe,
	input wire [5:0]             pad_slew_limit,
	input wire [5:0]             pad_ttl_level,
	input wire [5:0]             pin_level_port
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// Register port answers only in the cycle after a read
	a_pin3_no_drive: assert property (!pad_oe[3]) else $error("pin 3 driven");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	a_rdata_upper: assert property (reg_rdata[7:6] == 2'b00) else $error("upper bits set");
	a_dir_reads_in: assert property (reg_rd && reg_addr == `SPP_OFF_DIR |=> reg_rdata[3])
		else $error("pin 3 direction not input");
	a_unmapped_zero: assert property (reg_rd && reg_addr > `SPP_OFF_THRESH |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_analog_forced: assert property (reg_rd && reg_addr == `SPP_OFF_ANALOG |=>
		reg_rdata[5] == 1'b0 && reg_rdata[3] == 1'b0) else $error("analog bit on digital pin");
	// Pins 3 and 5 cannot be analog, so their level is the pad one cycle on
	a_level_follows: assert property ($past(rstn) |-> pin_level_port[5] == $past(pad_in[5])
		&& pin_level_port[3] == $past(pad_in[3])) else $error("level not from pad");
	a_reset_state: assert property ($rose(rstn) |-> pad_oe == 6'h00 &&
		pad_slew_limit == 6'h3f && pad_ttl_level == 6'h00) else $error("bad reset state");

	cover property (reg_rd && reg_addr == `SPP_OFF_LEVEL);
	cover property (pad_oe == 6'h37);
	cover property (pad_oe != 6'h00 && pad_oe != 6'h37);
endmodule // spp_port_monitor

bind spp_port spp_port_monitor spp_port_monitor_i (.clk(clk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
	.pad_oe(pad_oe), .pad_slew_limit(pad_slew_limit), .pad_ttl_level(pad_ttl_level),
	.pin_level_port(pin_level_port));

// file: tb/spp_pad_model.sv
/*
 Pads outside the port: resolve each wire from port drive and an
 external driver. Assumes weak pull-ups on all pads.
*/
`timescale 1ns/100ps

module spp_pad_model (
	input  wire [5:0] pad_out,
	input  wire [5:0] pad_oe,
	input  wire [5:0] ext_drv,
	input  wire [5:0] ext_en,
	output wire [5:0] pad_in
);
	// Released pins float up, so open-drain ones read high
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_drv) | (~pad_oe & ~ext_en);
endmodule // spp_pad_model

// file: tb/tb_top.sv
/*
 Testbench of the six-bit pin port: reset values, drive, open-drain,
 analog gating and output priority. Assumes rtl/ on the include path.
*/
`timescale 1ns/100ps
`include "spp_defs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch at %0t got %h exp %h", $time, g, e); end end

module tb_top;
	logic        clk, rstn, variant, reg_wr, reg_rd;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, steer, pv, pe;
	logic [5:0]  ext_drv, ext_en;
	wire  [7:0]  reg_rdata;
	wire  [5:0]  pad_in, pad_out, pad_oe, slew, ttl, lvl;
	int          n_errors, checks;
	logic [7:0]  rst_exp [8] = '{8'h28, 8'h3f, 8'h00, 8'h17, 8'h00, 8'h3f, 8'h00, 8'h00};
	// Variant, steering, peripheral values, expected driven pins
	logic [22:0] pri [4] = '{{1'b0, 8'h00, 8'ha3, 6'h17}, {1'b0, 8'h00, 8'h5c, 6'h00},
		{1'b0, 8'h61, 8'h5c, 6'h04}, {1'b1, 8'h02, 8'h5c, 6'h24}};

	spp_port spp_port_i (.clk(clk), .rstn(rstn), .variant(variant), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pin_steering_control(steer), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_slew_limit(slew), .pad_ttl_level(ttl), .pin_level_port(lvl),
		.dac_output(pv[0]), .dac_output_en(pe[0]), .waveform_out_a(pv[1]),
		.waveform_out_a_en(pe[1]), .waveform_out_b(pv[2]), .waveform_out_b_en(pe[2]),
		.capture_pwm1_out(pv[3]), .capture_pwm1_out_en(pe[3]), .capture_pwm2_out(pv[4]),
		.capture_pwm2_out_en(pe[4]), .zero_cross_output(pv[5]), .zero_cross_output_en(pe[5]),
		.comparator_output(pv[6]), .comparator_output_en(pe[6]),
		.clock_output_function(pv[7]), .clock_output_function_en(pe[7]));
	spp_pad_model spp_pad_model_i (.pad_out(pad_out), .pad_oe(pad_oe), .ext_drv(ext_drv),
		.ext_en(ext_en), .pad_in(pad_in));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Data stand only in the cycle after the strobe edge
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask

	task settle;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task results;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Hang guard
	initial begin
		#200000 n_errors++;
		results;
	end

	initial begin
		{rstn, variant, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{steer, pv, pe, ext_drv, ext_en} = '0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 8; i++) rd(i[3:0], rst_exp[i]);
		`CHK(pad_oe, 6'h00)
		$display("test reset done");
		@(posedge clk);
		ext_drv <= 6'h08; ext_en <= 6'h08;
		wr(`SPP_OFF_ANALOG, 8'h00); wr(`SPP_OFF_DIR, 8'h00); wr(`SPP_OFF_LEVEL, 8'h26);
		settle;
		`CHK(pad_oe, 6'h37)
		`CHK(pad_out & pad_oe, 6'h26)
		rd(`SPP_OFF_DIR, 8'h08);
		rd(`SPP_OFF_LEVEL, 8'h2e);
		`CHK(lvl, 6'h2e)
		rd(`SPP_OFF_LATCH, 8'h26);
		$display("test drive done");
		wr(`SPP_OFF_OPEN, 8'h3f); wr(`SPP_OFF_SLEW, 8'h00); wr(`SPP_OFF_THRESH, 8'h15);
		settle;
		`CHK(pad_oe, 6'h11)
		`CHK(pad_out & pad_oe, 6'h00)
		`CHK(slew, 6'h00)
		`CHK(ttl, 6'h15)
		wr(`SPP_OFF_OPEN, 8'h00);
		settle;
		`CHK(pad_oe, 6'h37)
		$display("test open drain done");
		wr(`SPP_OFF_ANALOG, 8'h3f);
		settle;
		rd(`SPP_OFF_ANALOG, 8'h17);
		`CHK(pad_oe, 6'h37)
		rd(`SPP_OFF_LEVEL, 8'h28);
		`CHK(lvl, 6'h28)
		$display("test analog done");
		wr(`SPP_OFF_LATCH, 8'h00);
		pe <= 8'hff;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			{variant, steer, pv} <= pri[i][22:6];
			settle;
			`CHK(pad_out & pad_oe, pri[i][5:0])
			`CHK(pad_oe, 6'h37)
		end
		// Alternate pins only show when higher functions are off
		@(posedge clk);
		{variant, steer, pv, pe} <= {1'b0, 8'h21, 8'h0c, 8'h0c};
		settle;
		`CHK(pad_out & pad_oe, 6'h30)
		@(posedge clk);
		steer <= 8'h00;
		settle;
		`CHK(pad_out & pad_oe, 6'h05)
		$display("test priority done");
		@(posedge clk);
		pe <= 8'h00;
		wr(`SPP_OFF_DIR, 8'h3f);
		settle;
		`CHK(pad_oe, 6'h00)
		rd(`SPP_OFF_LEVEL, 8'h28);
		$display("test release done");
		results;
	end
endmodule // tb_top
